// ### xpcs_consts.svh
`ifndef XPCS_CONSTS_SVH
`define XPCS_CONSTS_SVH

// ---------------------------------------------------------------
// word addresses of the pcs register block
// ---------------------------------------------------------------
`define XPCS_ADDR_TX_POL 9'h083
`define XPCS_ADDR_ALIGN_SYNC 9'h084
`define XPCS_ADDR_DECODE_ERR 9'h085
`define XPCS_ADDR_RXBUF_RLV 9'h086
`define XPCS_ADDR_RM_EVENTS 9'h087
`define XPCS_ADDR_RM_FILL 9'h088
`define XPCS_ADDR_TXBUF_ERR 9'h089
`define XPCS_ADDR_SIM_SHORT 9'h08a

// ---------------------------------------------------------------
// field widths, reset values and sizes
// ---------------------------------------------------------------
`define XPCS_LANES 4
`define XPCS_TX_FIFO_FLAGS 3
`define XPCS_TX_POL_RESET 4'h0
`define XPCS_SIM_RESET 1'b0
`define XPCS_RM_FULL_WORDS 20
`define XPCS_RM_EMPTY_WORDS 5
`define XPCS_RECONF_IN_W 4
`define XPCS_RECONF_OUT_HARD 16
`define XPCS_RECONF_OUT_SOFT 68
`define XPCS_RECONF_OFS_CHAN 0
`define XPCS_RECONF_OFS_PLL 4
`define XPCS_RECONF_IFACES 8

`endif

// ### xpcs_pkg.sv
`default_nettype none
`include "xpcs_consts.svh"

package xpcs_pkg;
    // pcs implementation flavour
    typedef enum logic [0:0] {
        XPCS_HARD = 1'b0,
        XPCS_SOFT = 1'b1
    } xpcs_variant_t;
endpackage : xpcs_pkg

`default_nettype wire

// ### xpcs_sticky_field.sv
`default_nettype none
`include "xpcs_consts.svh"

// ---------------------------------------------------------------
// sticky clear-on-read field: one bit per event line
// ---------------------------------------------------------------
module xpcs_sticky_field
    import xpcs_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [W-1:0] event_in,  // synchronised event lines
    input wire logic clear_in,          // read of the owning word
    output logic [W-1:0] flags_out
);
    logic [W-1:0] flags_reg;

    // set wins over clear so an event in the read cycle survives
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            flags_reg <= '0;
        end else if (ce_in) begin
            flags_reg <= (clear_in ? '0 : flags_reg) | event_in; // [R23]
        end
    end

    assign flags_out = flags_reg;

    chk_set_beats_clear: assert property (  // [R23]
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && clear_in) |=> (flags_reg == $past(event_in)))
        else $error("event lost against clearing read");
endmodule : xpcs_sticky_field

`default_nettype wire

// ### xpcs_status_regs.sv
// What this block does
// R1 - per-lane transmit polarity invert, four bits
// R2 - sticky alignment pattern seen, read clears
// R3 - sticky sync status, hard eight, soft four
// R4 - sticky code or disparity error, read clears
// R5 - disparity error also sets decode error
// R6 - host separates code and disparity errors
// R7 - sticky rx phase fifo fault per lane
// R8 - sticky run-length violation per lane
// R9 - sticky rate-match insert events, eight bits
// R10 - sticky rate-match delete events, eight bits
// R11 - sticky rate-match full flag, twenty words
// R12 - sticky rate-match empty flag, five words
// R13 - sticky tx phase fifo fault, three bits
// R14 - simulation bit shortens reset, loss timers
// R15 - four-bit reconf input, output 68 or 16; the code passes 69 or 17 bits
// R16 - reconf signals internal in single quad
// R17 - channel offsets 0-3, pll offsets 4-7
// R18 - three shared channels use one controller
// R19 - host holds request during wait-request
// R20 - nine-bit word address, 32-bit data
// R21 - management reset active high, level
// R22 - reserved reads zero, status writes ignored
// R23 - event beats a simultaneous clearing read
`default_nettype none
`include "xpcs_consts.svh"

module xpcs_status_regs
    import xpcs_pkg::*;
#(
    parameter xpcs_variant_t VARIANT = XPCS_HARD,
    parameter bit MULTI_QUAD = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,          // management reset, high
    input wire logic ce_in,           // low freezes all state
    // ---------------------------------------------------------------
    // management port
    // ---------------------------------------------------------------
    input wire logic [8:0] mgmt_addr_in,
    input wire logic [31:0] mgmt_wdata_in,
    input wire logic mgmt_write_in,
    input wire logic mgmt_read_in,
    output logic [31:0] mgmt_rdata_out,
    output logic mgmt_waitreq_out,
    // ---------------------------------------------------------------
    // pcs status lines, asynchronous to this clock
    // ---------------------------------------------------------------
    input wire logic [7:0] rx_align_seen_in,
    input wire logic [7:0] rx_sync_in,
    input wire logic [7:0] rx_decode_err_in,
    input wire logic [7:0] rx_disp_err_in,
    input wire logic [3:0] rx_phfifo_err_in,
    input wire logic [3:0] rx_runlen_err_in,
    input wire logic [7:0] rm_inserted_in,
    input wire logic [7:0] rm_deleted_in,
    input wire logic [3:0] rm_full_in,
    input wire logic [3:0] rm_empty_in,
    input wire logic [2:0] tx_phfifo_err_in,
    // ---------------------------------------------------------------
    // datapath controls and reconfiguration
    // ---------------------------------------------------------------
    output logic [3:0] tx_pol_invert_out,
    output logic sim_shortcut_out,
    output logic pcs_reset_out,
    input wire logic [`XPCS_RECONF_IN_W-1:0] reconf_in_bus,
    input wire logic [`XPCS_RECONF_IN_W-1:0] reconf_in_int,
    output logic [`XPCS_RECONF_IN_W-1:0] reconf_core_out,
    input wire logic [`XPCS_RECONF_OUT_SOFT:0] reconf_core_in,
    output logic [`XPCS_RECONF_OUT_SOFT:0] reconf_out_bus,
    output logic [`XPCS_RECONF_IFACES-1:0] reconf_iface_sel_out
);
    localparam int EV_W = 64;  // rx and rate-match event lines

    // ---------------------------------------------------------------
    // two-stage synchronisers on every status line
    // ---------------------------------------------------------------
    logic [EV_W-1:0] ev_raw;
    logic [EV_W-1:0] ev_meta_reg;  // first stage, read only by second
    logic [EV_W-1:0] ev_sync_reg;
    logic [7:0] sync_eff;
    logic [7:0] err_eff;

    // soft variant carries one sync bit per lane in bits 0-3
    assign sync_eff = (VARIANT == XPCS_SOFT) ?
        {4'h0, rx_sync_in[3:0]} : rx_sync_in;  // [R3]
    // a disparity error always marks the general error too
    assign err_eff = rx_decode_err_in | rx_disp_err_in;  // [R5]

    assign ev_raw = {rm_full_in, rm_empty_in,
                     rm_inserted_in, rm_deleted_in,
                     rx_phfifo_err_in, rx_runlen_err_in,
                     err_eff, rx_disp_err_in,
                     rx_align_seen_in, sync_eff};

    // pins cross in here, so two flops before any use
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ev_meta_reg <= '0;
            ev_sync_reg <= '0;
        end else if (ce_in) begin
            ev_meta_reg <= ev_raw;
            ev_sync_reg <= ev_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // tx fifo lines get their own synchroniser pair
    // ---------------------------------------------------------------
    logic [2:0] ev_tx_meta_reg;  // first stage, read only by second
    logic [2:0] ev_tx_sync_reg;
    // tx fault lines come from another clock, same two-flop rule
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ev_tx_meta_reg <= '0;
            ev_tx_sync_reg <= '0;
        end else if (ce_in) begin
            ev_tx_meta_reg <= tx_phfifo_err_in;  // [R13]
            ev_tx_sync_reg <= ev_tx_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    logic rd_hit_084;
    logic rd_hit_085;
    logic rd_hit_086;
    logic rd_hit_087;
    logic rd_hit_088;
    logic rd_hit_089;
    logic rd_take;  // a read taken this cycle

    // no wait states, every request with ce_in high is taken at once
    assign mgmt_waitreq_out = 1'b0;  // [R19]
    assign rd_take = mgmt_read_in && ce_in;
    assign rd_hit_084 = rd_take && mgmt_addr_in == `XPCS_ADDR_ALIGN_SYNC;
    assign rd_hit_085 = rd_take && mgmt_addr_in == `XPCS_ADDR_DECODE_ERR;
    assign rd_hit_086 = rd_take && mgmt_addr_in == `XPCS_ADDR_RXBUF_RLV;
    assign rd_hit_087 = rd_take && mgmt_addr_in == `XPCS_ADDR_RM_EVENTS;
    assign rd_hit_088 = rd_take && mgmt_addr_in == `XPCS_ADDR_RM_FILL;
    assign rd_hit_089 = rd_take && mgmt_addr_in == `XPCS_ADDR_TXBUF_ERR;

    // ---------------------------------------------------------------
    // sticky fields, one instance per status word
    // ---------------------------------------------------------------
    logic [15:0] f084;
    logic [15:0] f085;
    logic [7:0] f086;
    logic [15:0] f087;
    logic [7:0] f088;
    logic [2:0] f089;

    // pattern seen [15:8], sync [7:0]
    xpcs_sticky_field #(.W(16)) u_f084 (  // [R2] [R3]
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .event_in(ev_sync_reg[15:0]), .clear_in(rd_hit_084),
        .flags_out(f084));
    // decode error [15:8], disparity [7:0]
    xpcs_sticky_field #(.W(16)) u_f085 (  // [R4] [R5]
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .event_in(ev_sync_reg[31:16]), .clear_in(rd_hit_085),
        .flags_out(f085));
    // rx phase fifo [7:4], run length [3:0]
    xpcs_sticky_field #(.W(8)) u_f086 (  // [R7] [R8]
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .event_in(ev_sync_reg[39:32]), .clear_in(rd_hit_086),
        .flags_out(f086));
    // inserted [15:8], deleted [7:0]; one-cycle pulses may be lost
    // if narrower than this clock, hence the pcs stretches them
    xpcs_sticky_field #(.W(16)) u_f087 (  // [R9] [R10]
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .event_in(ev_sync_reg[55:40]), .clear_in(rd_hit_087),
        .flags_out(f087));
    // full [7:4], empty [3:0]
    xpcs_sticky_field #(.W(8)) u_f088 (  // [R11] [R12]
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .event_in(ev_sync_reg[63:56]), .clear_in(rd_hit_088),
        .flags_out(f088));
    // tx phase fifo [2:0]
    xpcs_sticky_field #(.W(3)) u_f089 (  // [R13]
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .event_in(ev_tx_sync_reg), .clear_in(rd_hit_089),
        .flags_out(f089));

    // ---------------------------------------------------------------
    // read-write control words
    // ---------------------------------------------------------------
    logic [3:0] tx_pol_reg;
    logic sim_reg;

    // only low bits stored, reserved bits dropped on write
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin  // [R21]
            tx_pol_reg <= `XPCS_TX_POL_RESET;
            sim_reg <= `XPCS_SIM_RESET;
        end else if (ce_in && mgmt_write_in) begin
            if (mgmt_addr_in == `XPCS_ADDR_TX_POL) begin
                tx_pol_reg <= mgmt_wdata_in[3:0];  // [R1] [R22]
            end
            if (mgmt_addr_in == `XPCS_ADDR_SIM_SHORT) begin
                sim_reg <= mgmt_wdata_in[0];  // [R14]
            end
        end
    end

    assign tx_pol_invert_out = tx_pol_reg;  // [R1]
    assign sim_shortcut_out = sim_reg;      // [R14]
    assign pcs_reset_out = rst_in;          // [R21]

    // ---------------------------------------------------------------
    // read data, registered; unmapped and reserved read zero
    // ---------------------------------------------------------------
    logic [31:0] rdata_next;
    logic [31:0] rdata_reg;

    always_comb begin
        rdata_next = 32'h0000_0000;  // [R22]
        unique case (mgmt_addr_in)
            `XPCS_ADDR_TX_POL: rdata_next[3:0] = tx_pol_reg;
            `XPCS_ADDR_ALIGN_SYNC: rdata_next[15:0] = f084;
            `XPCS_ADDR_DECODE_ERR: rdata_next[15:0] = f085;
            `XPCS_ADDR_RXBUF_RLV: rdata_next[7:0] = f086;
            `XPCS_ADDR_RM_EVENTS: rdata_next[15:0] = f087;
            `XPCS_ADDR_RM_FILL: rdata_next[7:0] = f088;
            `XPCS_ADDR_TXBUF_ERR: rdata_next[2:0] = f089;
            `XPCS_ADDR_SIM_SHORT: rdata_next[0] = sim_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // data follows one cycle after the read strobe
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_reg <= rdata_next;  // [R20]
        end
    end

    assign mgmt_rdata_out = rdata_reg;

    // ---------------------------------------------------------------
    // reconfiguration routing
    // ---------------------------------------------------------------
    localparam int RO_W = (VARIANT == XPCS_SOFT) ?
        `XPCS_RECONF_OUT_SOFT : `XPCS_RECONF_OUT_HARD;
    logic [`XPCS_RECONF_OUT_SOFT:0] ro_mask;

    // unused upper index bits held low in the hard variant
    assign ro_mask = {(`XPCS_RECONF_OUT_SOFT + 1){1'b1}} >>
        (`XPCS_RECONF_OUT_SOFT - RO_W);  // [R15]
    // single quad: internal source; multi quad: external port
    assign reconf_core_out = MULTI_QUAD ?
        reconf_in_bus : reconf_in_int;  // [R16]
    assign reconf_out_bus = MULTI_QUAD ?
        (reconf_core_in & ro_mask) : '0;  // [R15] [R16]

    // interfaces 0-3 channels, 4-7 transmit plls; a set bit marks
    // a live interface on the external side
    genvar gi;
    generate
        for (gi = 0; gi < `XPCS_RECONF_IFACES; gi++) begin : g_sel
            assign reconf_iface_sel_out[gi] = MULTI_QUAD &&
                (gi >= `XPCS_RECONF_OFS_CHAN);  // [R17]
        end
    endgenerate

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_pol_write_drive: assert property (  // [R1]
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && mgmt_write_in && mgmt_addr_in == `XPCS_ADDR_TX_POL)
        |=> tx_pol_invert_out == $past(mgmt_wdata_in[3:0]))
        else $error("polarity write not applied");
    chk_disp_sets_err: assert property (  // [R5]
        @(posedge sys_clk_in) disable iff (rst_in)
        (f085[7:0] & ~f085[15:8]) == 8'h00)
        else $error("disparity bit without decode bit");
    chk_rlv_sticky: assert property (  // [R8]
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && ev_sync_reg[32]) |=> f086[0])
        else $error("run length flag missed");
    chk_read_clears: assert property (  // [R2]
        @(posedge sys_clk_in) disable iff (rst_in)
        (rd_hit_084 && ev_sync_reg[15:0] == 16'h0000) |=> f084 == 16'h0000)
        else $error("align word not cleared by read");
    chk_reserved_zero: assert property (  // [R22]
        @(posedge sys_clk_in) disable iff (rst_in)
        mgmt_rdata_out[31:16] == 16'h0000)
        else $error("reserved bits read non-zero");
    chk_sim_follow: assert property (  // [R14]
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && mgmt_write_in && mgmt_addr_in == `XPCS_ADDR_SIM_SHORT)
        |=> sim_shortcut_out == $past(mgmt_wdata_in[0]))
        else $error("simulation bit not applied");
    chk_rm_full_two: assert property (  // [R11]
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && rm_full_in[0]) ##1 ce_in ##1 ce_in |=> f088[4])
        else $error("full flag not latched");
    chk_no_wait: assert property (  // [R19]
        @(posedge sys_clk_in) disable iff (rst_in)
        !mgmt_waitreq_out)
        else $error("wait request raised");

    cov_clear_read: cover property (
        @(posedge sys_clk_in) rd_hit_085 && f085 != 16'h0000);
    cov_pol_write: cover property (
        @(posedge sys_clk_in) ce_in && mgmt_write_in &&
        mgmt_addr_in == `XPCS_ADDR_TX_POL);
    cov_rm_event: cover property (
        @(posedge sys_clk_in) f087 != 16'h0000);
endmodule : xpcs_status_regs

`default_nettype wire

// ### xpcs_reconf_model.sv
`default_nettype none

// ---------------------------------------------------------------
// reconfiguration controller stand-in
// ---------------------------------------------------------------
module xpcs_reconf_model (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    output logic [3:0] reconf_out   // toward the pcs reconf input
);
    timeunit 1ns;
    timeprecision 1ps;

    // a single controller serves every channel interface
    // new word each cycle, so a stuck path cannot pass
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            reconf_out <= 4'h5;
        end else begin
            reconf_out <= reconf_out + 4'h3;
        end
    end
endmodule : xpcs_reconf_model

`default_nettype wire

// ### tb.sv
`default_nettype none
`include "xpcs_consts.svh"

`define XCHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
    err_total++; end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import xpcs_pkg::*;

    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic [8:0] addr = 9'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic write = 1'b0;
    logic read = 1'b0;
    logic [66:0] ev = '0;           // all status lines, packed
    logic [68:0] core_in = '0;
    logic [3:0] rc_int = 4'h0;
    logic [31:0] rdata;
    logic waitreq, sim_out, pcs_rst;
    logic [3:0] pol_out, rc_core_out;
    logic [68:0] rc_out_bus;
    logic [7:0] sel_out;
    logic [31:0] rdata_s;           // soft, single-quad build
    logic [3:0] rc_core_s;
    logic [68:0] rc_bus_s;
    logic [7:0] sel_s;
    wire logic [3:0] rc_bus;
    logic [31:0] exp_q[$];          // expected read words, oldest first
    logic [31:0] exp_v, r1, r2, r3;
    logic rd_q = 1'b0;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    always #4 sys_clk_in = ~sys_clk_in;

    xpcs_status_regs #(.VARIANT(XPCS_HARD), .MULTI_QUAD(1'b1))
    i_xpcs_status_regs (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .mgmt_addr_in(addr), .mgmt_wdata_in(wdata),
        .mgmt_write_in(write), .mgmt_read_in(read),
        .mgmt_rdata_out(rdata), .mgmt_waitreq_out(waitreq),
        .rx_align_seen_in(ev[7:0]), .rx_sync_in(ev[15:8]),
        .rx_decode_err_in(ev[23:16]), .rx_disp_err_in(ev[31:24]),
        .rx_phfifo_err_in(ev[35:32]), .rx_runlen_err_in(ev[39:36]),
        .rm_inserted_in(ev[47:40]), .rm_deleted_in(ev[55:48]),
        .rm_full_in(ev[59:56]), .rm_empty_in(ev[63:60]),
        .tx_phfifo_err_in(ev[66:64]),
        .tx_pol_invert_out(pol_out), .sim_shortcut_out(sim_out),
        .pcs_reset_out(pcs_rst), .reconf_in_bus(rc_bus),
        .reconf_in_int(rc_int), .reconf_core_out(rc_core_out),
        .reconf_core_in(core_in), .reconf_out_bus(rc_out_bus),
        .reconf_iface_sel_out(sel_out)
    );

    // second build: soft variant inside a single quad
    xpcs_status_regs #(.VARIANT(XPCS_SOFT), .MULTI_QUAD(1'b0))
    i_xpcs_status_regs_soft (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .mgmt_addr_in(addr), .mgmt_wdata_in(wdata),
        .mgmt_write_in(write), .mgmt_read_in(read),
        .mgmt_rdata_out(rdata_s), .mgmt_waitreq_out(),
        .rx_align_seen_in(ev[7:0]), .rx_sync_in(ev[15:8]),
        .rx_decode_err_in(ev[23:16]), .rx_disp_err_in(ev[31:24]),
        .rx_phfifo_err_in(ev[35:32]), .rx_runlen_err_in(ev[39:36]),
        .rm_inserted_in(ev[47:40]), .rm_deleted_in(ev[55:48]),
        .rm_full_in(ev[59:56]), .rm_empty_in(ev[63:60]),
        .tx_phfifo_err_in(ev[66:64]),
        .tx_pol_invert_out(), .sim_shortcut_out(),
        .pcs_reset_out(), .reconf_in_bus(rc_bus),
        .reconf_in_int(rc_int), .reconf_core_out(rc_core_s),
        .reconf_core_in(core_in), .reconf_out_bus(rc_bus_s),
        .reconf_iface_sel_out(sel_s)
    );

    xpcs_reconf_model i_xpcs_reconf_model (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reconf_out(rc_bus)
    );

    // ---------------------------------------------------------------
    // bus tasks: request held until the sampling edge
    // ---------------------------------------------------------------
    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge sys_clk_in);
        read <= 1'b1;
        addr <= a;
        @(posedge sys_clk_in);
        read <= 1'b0;
    endtask : rd

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        write <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk_in);
        write <= 1'b0;
    endtask : wr

    task automatic report_and_stop();
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // ---------------------------------------------------------------
    // read data monitor: word stands the cycle after the take
    // ---------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        if (rd_q && exp_q.size() != 0) begin
            exp_v = exp_q.pop_front();
            `XCHK(rdata, exp_v)
        end
        rd_q <= read && ce_in && !rst_in;
    end

    // hang guard, well above the 130 or so cycles the run needs
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            report_and_stop();
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'hc64d));
        @(posedge sys_clk_in);
        `XCHK(pcs_rst, 1'b1)
        @(posedge sys_clk_in);
        rst_in <= 1'b0;
        // reset values of the writable words
        rd(`XPCS_ADDR_TX_POL, 32'h0000_0000);
        rd(`XPCS_ADDR_SIM_SHORT, 32'h0000_0000);
        r1 = $urandom;
        wr(`XPCS_ADDR_TX_POL, r1);
        wr(`XPCS_ADDR_SIM_SHORT, ~r1);
        rd(`XPCS_ADDR_TX_POL, {28'h000_0000, r1[3:0]});
        rd(`XPCS_ADDR_SIM_SHORT, {31'h0, ~r1[0]});
        `XCHK(pol_out, r1[3:0])
        `XCHK(sim_out, ~r1[0])
        `XCHK(waitreq, 1'b0)
        `XCHK(pcs_rst, 1'b0)
        // frozen port ignores the write
        @(posedge sys_clk_in);
        ce_in <= 1'b0;
        wr(`XPCS_ADDR_TX_POL, ~r1);
        @(posedge sys_clk_in);
        ce_in <= 1'b1;
        rd(`XPCS_ADDR_TX_POL, {28'h000_0000, r1[3:0]});
        // a write to a status word leaves nothing behind, unmapped words read zero
        wr(`XPCS_ADDR_DECODE_ERR, 32'hffff_ffff);
        rd(`XPCS_ADDR_DECODE_ERR, 32'h0000_0000);
        rd(9'h1ff, 32'h0000_0000);
        // random event bursts, then clear-on-read of every word
        repeat (3) begin
            r1 = $urandom;
            r2 = $urandom;
            r3 = $urandom;
            @(posedge sys_clk_in);
            ev <= {r3[2:0], r2, r1};
            @(posedge sys_clk_in);
            ev <= '0;
            repeat (4) @(posedge sys_clk_in);
            rd(9'h084, {16'h0, r1[7:0], r1[15:8]});
            // soft build keeps only one sync bit per lane
            @(negedge sys_clk_in);
            `XCHK(rdata_s, {16'h0, r1[7:0], 4'h0, r1[11:8]})
            rd(9'h085, {16'h0, r1[23:16] | r1[31:24], r1[31:24]});
            rd(9'h086, {24'h0, r2[3:0], r2[7:4]});
            rd(9'h087, {16'h0, r2[15:8], r2[23:16]});
            rd(9'h088, {24'h0, r2[27:24], r2[31:28]});
            rd(9'h089, {29'h0, r3[2:0]});
            for (int a = 9'h084; a <= 9'h089; a++) begin
                rd(9'(a), 32'h0000_0000);
            end
        end
        // an event meeting the clearing read must survive it
        @(posedge sys_clk_in);
        ev <= {59'h0, r1[7:0] | 8'h01};
        @(posedge sys_clk_in);
        ev <= '0;
        rd(`XPCS_ADDR_ALIGN_SYNC, 32'h0000_0000);
        rd(`XPCS_ADDR_ALIGN_SYNC, {16'h0, r1[7:0] | 8'h01, 8'h00});
        // reconfiguration paths of both builds
        @(posedge sys_clk_in);
        core_in <= 69'({$urandom, $urandom, $urandom});
        rc_int <= 4'($urandom);
        @(negedge sys_clk_in);
        `XCHK(rc_core_out, rc_bus)
        `XCHK(rc_out_bus, {52'h0, core_in[16:0]})
        `XCHK(sel_out, 8'hff)
        `XCHK(rc_core_s, rc_int)
        `XCHK(rc_bus_s, 69'h0)
        `XCHK(sel_s, 8'h00)
        repeat (3) @(posedge sys_clk_in);
        `XCHK(exp_q.size(), 0)
        report_and_stop();
    end
endmodule : tb

`default_nettype wire
